/* crag_core.sv */
// cpu register file, status flags and effective address generation, wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
import crag_pkg::*;
module crag_core import crag_pkg::*; (
  input wire logic clk_sys, // core clock
  input wire logic rst_b, // async reset, low active
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic [19:0] ea_q, // effective 20-bit address
  output logic irq_gate_q // maskable interrupt gate
);
  logic [7:0] acc_q, flg_q, b_q, c_q, d_q, e_q, h_q, l_q;
  logic [7:0] acc_s_q, flg_s_q, b_s_q, c_s_q, d_s_q, e_s_q, h_s_q, l_s_q;
  logic [15:0] ix_q, iy_q, sp_q, pc_q;
  logic [7:0] opa_q, opb_q;
  logic [15:0] disp_q;
  logic swap_tog_q = 1'b0; // power-up value only, so the first swap never inverts an unknown
  logic [31:0] rd_d;
  logic req, wr, rd_sel;
  logic [3:0] bank_x, bank_y;
  logic [7:0] bank_rd;
  logic [15:0] mem_adr_q;
  logic bank_wr;
  crag_op_t op;
  crag_ptr_t ptr;
  logic cmd_go;

  function automatic logic lane_hit(input logic [7:0] adr, input logic [7:0] reg_off);
    lane_hit = (adr == reg_off);
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign cmd_go = wr && lane_hit(wb_adr_i, R_CMD) && wb_sel_i[0];
  assign op = crag_op_t'(wb_dat_i[4:0]);
  assign ptr = crag_ptr_t'(wb_dat_i[9:8]);
  // memory mapped write into the I/O page: only the bank nibbles hold storage
  assign bank_wr = wr && lane_hit(wb_adr_i, R_MEMIO) && wb_sel_i[0] &&
                   (wb_dat_i[31:16] == BANK_X_ADDR || wb_dat_i[31:16] == BANK_Y_ADDR);
  assign rd_sel = (mem_adr_q == BANK_Y_ADDR);

  crag_bank u_bank (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(bank_wr),
    .wr_sel(wb_dat_i[16]),
    .wr_data(wb_dat_i[3:0]),
    .rd_sel(rd_sel),
    .rd_data(bank_rd),
    .bank_x(bank_x),
    .bank_y(bank_y)
  );

  // alu result and flags
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic is_sub, cin, v_arith;
  always_comb begin
    is_sub = (op == OP_SUB) || (op == OP_SBC) || (op == OP_CP) || (op == OP_DEC);
    cin = ((op == OP_ADC) || (op == OP_SBC)) ? flg_q[FLG_C] : 1'b0;
    if (op == OP_INC || op == OP_DEC) begin
      sum9 = is_sub ? ({1'b0, opa_q} - 9'h001) : ({1'b0, opa_q} + 9'h001);
      sum5 = is_sub ? ({1'b0, opa_q[3:0]} - 5'h01) : ({1'b0, opa_q[3:0]} + 5'h01);
    end else if (is_sub) begin
      sum9 = {1'b0, opa_q} - {1'b0, opb_q} - {8'h00, cin};
      sum5 = {1'b0, opa_q[3:0]} - {1'b0, opb_q[3:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, opa_q} + {1'b0, opb_q} + {8'h00, cin};
      sum5 = {1'b0, opa_q[3:0]} + {1'b0, opb_q[3:0]} + {4'h0, cin};
    end
    unique case (op)
      OP_AND: res = opa_q & opb_q;
      OP_OR: res = opa_q | opb_q;
      OP_XOR: res = opa_q ^ opb_q;
      default: res = sum9[7:0];
    endcase
    v_arith = is_sub ? ((opa_q[7] != opb_q[7]) && (res[7] != opa_q[7]))
                     : ((opa_q[7] == opb_q[7]) && (res[7] != opa_q[7]));
  end
  logic is_alu, is_logic;
  assign is_logic = (op == OP_AND) || (op == OP_OR) || (op == OP_XOR);
  assign is_alu = is_logic || (op == OP_ADD) || (op == OP_ADC) || is_sub || (op == OP_INC);

  // accumulator and status, with shadow swap
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= 8'h00;
      flg_q <= 8'h00;
      acc_s_q <= 8'h00;
      flg_s_q <= 8'h00;
    end else if (cmd_go && op == OP_SWAP_AF) begin
      acc_q <= acc_s_q;
      acc_s_q <= acc_q;
      flg_q <= {flg_s_q[7:6], flg_q[FLG_I], flg_s_q[4:0]};
      flg_s_q <= {flg_q[7:6], flg_s_q[FLG_I], flg_q[4:0]};
    end else if (cmd_go && is_alu) begin
      if (op != OP_CP) acc_q <= res;
      flg_q[FLG_S] <= res[7];
      flg_q[FLG_Z] <= (res == 8'h00);
      flg_q[FLG_V] <= is_logic ? ~^res : v_arith;
      flg_q[FLG_C] <= is_logic ? 1'b0 : sum9[8];
      flg_q[FLG_X] <= is_logic ? 1'b0 : sum9[8];
      flg_q[FLG_H] <= is_logic ? 1'b0 : sum5[4];
      flg_q[FLG_N] <= is_sub;
    end else if (cmd_go && op == OP_INC16) begin
      flg_q[FLG_X] <= ({h_q, l_q} == 16'hffff);
    end else if (cmd_go && op == OP_EI) begin
      flg_q[FLG_I] <= 1'b1;
    end else if (cmd_go && op == OP_DI) begin
      flg_q[FLG_I] <= 1'b0;
    end else if (wr && lane_hit(wb_adr_i, R_ACCF) && wb_sel_i[0]) begin
      acc_q <= wb_dat_i[7:0];
    end
  end

  // general registers, pairs and shadow bank
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {b_q, c_q, d_q, e_q, h_q, l_q} <= 48'h0;
      {b_s_q, c_s_q, d_s_q, e_s_q, h_s_q, l_s_q} <= 48'h0;
    end else if (cmd_go && op == OP_SWAP_GEN) begin
      {b_q, c_q, d_q, e_q, h_q, l_q} <= {b_s_q, c_s_q, d_s_q, e_s_q, h_s_q, l_s_q};
      {b_s_q, c_s_q, d_s_q, e_s_q, h_s_q, l_s_q} <= {b_q, c_q, d_q, e_q, h_q, l_q};
    end else if (cmd_go && op == OP_INC16) begin
      {h_q, l_q} <= {h_q, l_q} + 16'h0001;
    end else if (cmd_go && op == OP_LOOP_DECREMENT_BRANCH) begin
      if (wb_dat_i[10]) {b_q, c_q} <= {b_q, c_q} - 16'h0001;
      else b_q <= b_q - 8'h01;
    end else if (wr && wb_sel_i[1:0] == 2'b11) begin
      if (lane_hit(wb_adr_i, R_BC)) {b_q, c_q} <= wb_dat_i[15:0];
      if (lane_hit(wb_adr_i, R_DE)) {d_q, e_q} <= wb_dat_i[15:0];
      if (lane_hit(wb_adr_i, R_HL)) {h_q, l_q} <= wb_dat_i[15:0];
    end
  end

  // toggle bit keeps its value across reset by design
  always_ff @(posedge clk_sys) begin
    if (cmd_go && op == OP_SWAP_GEN) swap_tog_q <= ~swap_tog_q;
  end

  // operands and displacement
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      opa_q <= 8'h00;
      opb_q <= 8'h00;
      disp_q <= 16'h0000;
      mem_adr_q <= 16'h0000;
    end else begin
      if (wr && lane_hit(wb_adr_i, R_OPA) && wb_sel_i[0]) opa_q <= wb_dat_i[7:0];
      if (wr && lane_hit(wb_adr_i, R_OPB) && wb_sel_i[0]) opb_q <= wb_dat_i[7:0];
      if (wr && lane_hit(wb_adr_i, R_DISP) && wb_sel_i[1:0] == 2'b11) disp_q <= wb_dat_i[15:0];
      if (wr && lane_hit(wb_adr_i, R_MEMIO)) mem_adr_q <= wb_dat_i[31:16];
    end
  end

  // pointers: index, stack, program counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ix_q <= 16'h0000;
      iy_q <= 16'h0000;
      sp_q <= SP_RESET;
      pc_q <= PC_RESET;
    end else if (cmd_go) begin
      unique case (op)
        OP_PUSH, OP_CALL, OP_IRQ: sp_q <= sp_q - 16'h0001;
        OP_POP, OP_RET: sp_q <= sp_q + 16'h0001;
        OP_SETPC: pc_q <= disp_q;
        OP_EA_REL: if (wb_dat_i[11]) begin
          pc_q <= pc_q + REL_BIAS + (wb_dat_i[12] ? disp_q : {{8{disp_q[7]}}, disp_q[7:0]});
        end
        default: ;
      endcase
    end else if (wr && lane_hit(wb_adr_i, R_IXIY) && wb_sel_i == 4'hf) begin
      {iy_q, ix_q} <= wb_dat_i;
    end else if (wr && lane_hit(wb_adr_i, R_SPPC) && wb_sel_i[1:0] == 2'b11) begin
      sp_q <= wb_dat_i[15:0];
    end
  end

  // effective address generation
  logic [15:0] base, sx8, acc_sx;
  logic [3:0] bank_of;
  always_comb begin
    unique case (ptr)
      SEL_IX: begin base = ix_q; bank_of = bank_x; end
      SEL_IY: begin base = iy_q; bank_of = bank_y; end
      SEL_SP: begin base = sp_q; bank_of = 4'h0; end
      SEL_HL: begin base = {h_q, l_q}; bank_of = 4'h0; end
    endcase
    sx8 = {{8{disp_q[7]}}, disp_q[7:0]};
    acc_sx = {{8{acc_q[7]}}, acc_q};
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) ea_q <= 20'h00000;
    else if (cmd_go) begin
      unique case (op)
        OP_EA_IND: ea_q <= {bank_of, base};
        OP_EA_IDX: ea_q <= {bank_of, base + sx8};
        OP_EA_HLA: ea_q <= {4'h0, {h_q, l_q} + acc_sx};
        OP_EA_DIR: ea_q <= {4'h0, DIRECT_PAGE, disp_q[7:0]};
        OP_EA_EXT: ea_q <= {4'h0, disp_q};
        OP_EA_REL: ea_q <= {4'h0, pc_q + REL_BIAS + (wb_dat_i[12] ? disp_q : sx8)};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) irq_gate_q <= 1'b0;
    else irq_gate_q <= flg_q[FLG_I];
  end

  // read mux; one cycle to ack, unmapped reads return zero
  always_comb begin
    unique case (wb_adr_i)
      R_OPA: rd_d = {24'h0, opa_q};
      R_OPB: rd_d = {24'h0, opb_q};
      R_DISP: rd_d = {16'h0, disp_q};
      R_ACCF: rd_d = {16'h0, acc_q, flg_q};
      R_BC: rd_d = {16'h0, b_q, c_q};
      R_DE: rd_d = {16'h0, d_q, e_q};
      R_HL: rd_d = {16'h0, h_q, l_q};
      R_IXIY: rd_d = {iy_q, ix_q};
      R_SPPC: rd_d = {pc_q, sp_q};
      R_EA: rd_d = {12'h0, ea_q};
      R_BANKS: rd_d = {16'h0, 4'hf, bank_y, 4'hf, bank_x};
      R_MEMIO: rd_d = {mem_adr_q, 8'h0,
                       (mem_adr_q == SWAP_STAT_ADDR) ? {6'h0, swap_tog_q, 1'b0} : bank_rd};
      default: rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rd_d : 32'h0;
    end
  end

  property p_zero;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && is_alu |=> flg_q[FLG_Z] == (acc_q == 8'h00) || $past(op) == OP_CP;
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sign;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && is_alu && op != OP_CP |=> flg_q[FLG_S] == acc_q[7];
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_ei;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && op == OP_EI |=> ##1 irq_gate_q;
  endproperty
  a_ei: assert property (p_ei) else $error("irq gate not set");
  property p_swap_keep_i;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && op == OP_SWAP_AF |=> flg_q[FLG_I] == $past(flg_q[FLG_I]);
  endproperty
  a_swap_keep_i: assert property (p_swap_keep_i) else $error("irq gate swapped");
  property p_push;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && op == OP_PUSH |=> sp_q == $past(sp_q) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("stack pointer not decremented");
  property p_tog;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && op == OP_SWAP_GEN |=> swap_tog_q != $past(swap_tog_q);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle bit not inverted");
  property p_dir;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && op == OP_EA_DIR |=> ea_q[19:8] == 12'h0ff;
  endproperty
  a_dir: assert property (p_dir) else $error("direct page wrong");
  property p_nobank;
    @(posedge clk_sys) disable iff (!rst_b) cmd_go && (op == OP_EA_EXT || op == OP_EA_HLA) |=> ea_q[19:16] == 4'h0;
  endproperty
  a_nobank: assert property (p_nobank) else $error("bank lines not zero");
  property p_ack;
    @(posedge clk_sys) disable iff (!rst_b) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule

/* crag_pkg.sv */
// shared constants and types for the cpu register file and address generator
package crag_pkg;
  localparam logic [15:0] BANK_X_ADDR = 16'hffec;
  localparam logic [15:0] BANK_Y_ADDR = 16'hffed;
  localparam logic [15:0] SWAP_STAT_ADDR = 16'hffd2;
  localparam int SWAP_BIT_POS = 1;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [7:0] DIRECT_PAGE = 8'hff;
  localparam logic [15:0] REL_BIAS = 16'h0002;
  // status register layout (bit positions)
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_I = 5;
  localparam int FLG_H = 4;
  localparam int FLG_X = 3;
  localparam int FLG_V = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;
  // core command register offsets (word aligned byte addresses)
  localparam logic [7:0] R_CMD = 8'h00;
  localparam logic [7:0] R_OPA = 8'h04;
  localparam logic [7:0] R_OPB = 8'h08;
  localparam logic [7:0] R_DISP = 8'h0c;
  localparam logic [7:0] R_ACCF = 8'h10;
  localparam logic [7:0] R_BC = 8'h14;
  localparam logic [7:0] R_DE = 8'h18;
  localparam logic [7:0] R_HL = 8'h1c;
  localparam logic [7:0] R_IXIY = 8'h20;
  localparam logic [7:0] R_SPPC = 8'h24;
  localparam logic [7:0] R_EA = 8'h28;
  localparam logic [7:0] R_BANKS = 8'h2c;
  localparam logic [7:0] R_MEMIO = 8'h30;
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC,
    OP_INC16, OP_SWAP_AF, OP_SWAP_GEN, OP_EI, OP_DI, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_IRQ,
    OP_EA_IND, OP_EA_IDX, OP_EA_HLA, OP_EA_DIR, OP_EA_EXT, OP_EA_REL, OP_LOOP_DECREMENT_BRANCH, OP_SETPC
  } crag_op_t;
  typedef enum logic [1:0] {SEL_IX, SEL_IY, SEL_SP, SEL_HL} crag_ptr_t;
endpackage

/* crag_bank.sv */
// two 4-bit bank nibbles with all-ones upper read bits
module crag_bank import crag_pkg::*; (
  input wire logic clk_sys, // core clock
  input wire logic rst_b, // async reset, low active
  input wire logic wr_en, // write strobe
  input wire logic wr_sel, // 0 first bank, 1 second bank
  input wire logic [3:0] wr_data, // nibble to store
  input wire logic rd_sel, // read select
  output logic [7:0] rd_data, // registered read data
  output logic [3:0] bank_x, // first_bank_nibble
  output logic [3:0] bank_y // second_bank_nibble
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bank_x <= BANK_RESET;
      bank_y <= BANK_RESET;
    end else if (wr_en) begin
      if (wr_sel) bank_y <= wr_data;
      else bank_x <= wr_data;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) rd_data <= 8'hf0;
    else rd_data <= {4'hf, rd_sel ? bank_y : bank_x};
  end
  property p_bank_upper;
    @(posedge clk_sys) disable iff (!rst_b) rd_data[7:4] == 4'hf;
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper bits not ones");
  property p_bank_wr;
    @(posedge clk_sys) disable iff (!rst_b) wr_en && !wr_sel |=> bank_x == $past(wr_data);
  endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("first bank write lost");
endmodule

/* cpu_register_and_address_gen_tb.sv */
// self-checking bench for the cpu register file and address generator
module cpu_register_and_address_gen_tb import crag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, cyc, stb, we, ack, gate;
  logic [7:0] adr, ma, mf, a, b;
  logic [3:0] sel;
  logic [31:0] dw, dr, rd;
  logic [19:0] ea;
  logic [15:0] e;
  crag_op_t op;
  int failures, total_checks, seed;
  crag_op_t eop[12] = '{OP_EA_IND, OP_EA_IND, OP_EA_IDX, OP_EA_IDX, OP_EA_IDX, OP_EA_IND, OP_EA_HLA, OP_EA_DIR,
    OP_EA_EXT, OP_EA_REL, OP_EA_REL, OP_EA_REL};
  logic [1:0] eptr[12] = '{0, 1, 0, 1, 2, 3, 3, 0, 0, 0, 0, 0};
  logic [2:0] efl[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3'b010, 3'b110};
  logic [15:0] edisp[12] = '{0, 0, 'h20, 'h80, 5, 0, 0, 'h34, 'h2000, 'h32, 'hfe, 'h8000};
  logic [19:0] eexp[12] = '{'hafff0, 'h61000, 'ha0010, 'h60f80, 'h03005, 'h02000, 'h01ffd, 'h0ff34, 'h02000,
    'h02034, 'h02000, 'h0a002};
  crag_op_t sop[3] = '{OP_PUSH, OP_CALL, OP_IRQ};
  crag_op_t uop[3] = '{OP_POP, OP_RET, OP_POP};

  crag_core crag_core_i (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .ea_q(ea), .irq_gate_q(gate));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held from just after an edge until ack is sampled high at a rising edge
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dw <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("Error ack expected 1 seen timeout");
      results();
    end
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task cmd(input crag_op_t o, input logic [1:0] p, input logic [2:0] fl);
    bus(1'b1, R_CMD, {19'h0, fl, p, 3'h0, o});
  endtask

  task reset_chk;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(1'b0, R_SPPC, 32'h0);
    chk("pc sp", 32'h0, rd);
    bus(1'b0, R_BANKS, 32'h0);
    chk("banks", 32'h0000f0f0, rd);
    ma = 8'h00;
    mf = 8'h00;
  endtask

  function logic [15:0] alu(input crag_op_t o, input logic [7:0] x, input logic [7:0] y, input logic [7:0] f);
    logic [8:0] r;
    logic [4:0] h;
    logic ci;
    logic sb;
    logic [7:0] n;
    ci = (o == OP_ADC || o == OP_SBC) ? f[FLG_C] : 1'b0;
    sb = o inside {OP_SUB, OP_SBC, OP_CP};
    r = sb ? {1'b0, x} - {1'b0, y} - 9'(ci) : {1'b0, x} + {1'b0, y} + 9'(ci);
    h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(ci) : {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(ci);
    n = 8'h00;
    n[FLG_I] = f[FLG_I];
    if (o inside {OP_AND, OP_OR, OP_XOR}) begin
      r = {1'b0, (o == OP_AND ? x & y : (o == OP_OR ? x | y : x ^ y))};
      n[FLG_V] = ~^r[7:0];
    end else begin
      n[FLG_V] = (sb ? x[7] ^ y[7] : x[7] ~^ y[7]) & (x[7] ^ r[7]);
      n[FLG_C] = r[8];
      n[FLG_X] = r[8];
      n[FLG_H] = h[4];
      n[FLG_N] = sb;
    end
    n[FLG_S] = r[7];
    n[FLG_Z] = r[7:0] == 8'h00;
    return {r[7:0], n};
  endfunction

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("Error watchdog expected done seen timeout");
    results();
  end

  initial begin
    {cyc, stb, we, adr, dw} = '0;
    sel = 4'hf;
    seed = 38;
    rst_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    reset_chk();
    cmd(OP_EI, 2'd0, 3'd0);
    mf[FLG_I] = 1'b1;
    // first cases run add, adc, sub and sbc and hit overflow and half carry before random traffic
    for (int i = 0; i < 48; i++) begin
      a = (i < 4) ? 8'h7f << i : 8'($random(seed));
      b = (i < 4) ? 8'h01 : 8'($random(seed));
      op = (i < 4) ? crag_op_t'(i + 1) : crag_op_t'(5'(1 + {$random(seed)} % 8));
      bus(1'b1, R_OPA, {24'h0, a});
      bus(1'b1, R_OPB, {24'h0, b});
      cmd(op, 2'd0, 3'd0);
      bus(1'b0, R_ACCF, 32'h0);
      e = alu(op, a, b, mf);
      if (op != OP_CP) ma = e[15:8];
      mf = e[7:0];
      chk("acc flags", {16'h0, ma, mf}, rd);
    end
    chk("irq gate", 32'h1, {31'h0, gate});
    $display("test alu done");
    cmd(OP_SWAP_AF, 2'd0, 3'd0);
    bus(1'b0, R_ACCF, 32'h0);
    chk("shadow af", 32'h0020, rd);
    cmd(OP_SWAP_AF, 2'd0, 3'd0);
    cmd(OP_DI, 2'd0, 3'd0);
    bus(1'b0, R_ACCF, 32'h0);
    mf[FLG_I] = 1'b0;
    chk("af back", {16'h0, ma, mf}, rd);
    chk("irq gate", 32'h0, {31'h0, gate});
    bus(1'b1, R_BC, 32'h1234);
    bus(1'b1, R_HL, 32'hbeef);
    cmd(OP_SWAP_GEN, 2'd0, 3'd0);
    bus(1'b0, R_BC, 32'h0);
    chk("shadow bc", 32'h0, rd);
    cmd(OP_SWAP_GEN, 2'd0, 3'd0);
    bus(1'b0, R_HL, 32'h0);
    chk("hl back", 32'hbeef, rd);
    bus(1'b1, R_BC, 32'h0200);
    cmd(OP_LOOP_DECREMENT_BRANCH, 2'd0, 3'd0);
    bus(1'b0, R_BC, 32'h0);
    chk("loop_decrement_branch b", 32'h0100, rd);
    cmd(OP_LOOP_DECREMENT_BRANCH, 2'd0, 3'b001);
    bus(1'b0, R_BC, 32'h0);
    chk("loop_decrement_branch bc", 32'h00ff, rd);
    bus(1'b1, R_HL, 32'hffff);
    cmd(OP_INC16, 2'd0, 3'd0);
    bus(1'b0, R_ACCF, 32'h0);
    chk("x and c", {30'h0, 1'b1, mf[FLG_C]}, {30'h0, rd[FLG_X], rd[FLG_C]});
    $display("test swap done");
    bus(1'b1, R_MEMIO, 32'hffec00fa);
    bus(1'b1, R_MEMIO, 32'hffed0006);
    bus(1'b1, R_MEMIO, 32'hffee0003);
    bus(1'b0, R_BANKS, 32'h0);
    chk("banks", 32'h0000f6fa, rd);
    bus(1'b1, R_MEMIO, 32'hffec0000);
    bus(1'b1, R_MEMIO, 32'hffec000a);
    bus(1'b0, R_MEMIO, 32'h0);
    chk("memio", 32'hffecfa, {rd[31:16], rd[7:0]});
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, R_IXIY, 32'h1000fff0);
    bus(1'b1, R_SPPC, 32'h3000);
    bus(1'b1, R_HL, 32'h2000);
    bus(1'b1, R_ACCF, 32'h00fd);
    bus(1'b1, R_DISP, 32'h2000);
    cmd(OP_SETPC, 2'd0, 3'd0);
    for (int j = 0; j < 12; j++) begin
      bus(1'b1, R_DISP, {16'h0, edisp[j]});
      cmd(eop[j], eptr[j], efl[j]);
      bus(1'b0, R_EA, 32'h0);
      chk("ea reg", {12'h0, eexp[j]}, rd);
      chk("ea port", {12'h0, eexp[j]}, {12'h0, ea});
    end
    bus(1'b0, R_SPPC, 32'h0);
    chk("pc sp", 32'ha0023000, rd);
    $display("test address done");
    for (int k = 0; k < 3; k++) begin
      cmd(sop[k], 2'd0, 3'd0);
      bus(1'b0, R_SPPC, 32'h0);
      chk("sp down", 32'h2fff, {16'h0, rd[15:0]});
      cmd(uop[k], 2'd0, 3'd0);
      bus(1'b0, R_SPPC, 32'h0);
      chk("sp up", 32'h3000, {16'h0, rd[15:0]});
    end
    $display("test stack done");
    bus(1'b1, R_MEMIO, 32'hffd20000);
    bus(1'b0, R_MEMIO, 32'h0);
    e[0] = rd[SWAP_BIT_POS];
    cmd(OP_SWAP_GEN, 2'd0, 3'd0);
    bus(1'b0, R_MEMIO, 32'h0);
    chk("toggle", {31'h0, ~e[0]}, {31'h0, rd[SWAP_BIT_POS]});
    reset_chk();
    bus(1'b1, R_MEMIO, 32'hffd20000);
    bus(1'b0, R_MEMIO, 32'h0);
    chk("toggle kept", {31'h0, ~e[0]}, {31'h0, rd[SWAP_BIT_POS]});
    $display("test reset done");
    results();
  end
endmodule
